// ===== hdl/ctb_top.sv
/*
 * ctb_top: core timebase, reset qualification, prescaler, timers,
 * watchdog, interrupt poll gate and port mode registers.
 * assumes: aclk is the crystal clock itself, all pins asynchronous,
 * cpu poll strobe on aclk, AXI4-Lite master on aclk.
 */
//
// Overview of operation
// - core clock equals crystal input, never divided
// - interrupts polled in every instruction's last cycle
// - only flags latched before last cycle count
// - both external interrupt pins sampled every clock
// - timers advance once per prescaler tick, or per counter pin edge
// - one prescaler; value 1011B gives twelve clocks
// - both counter pins sampled every clock
// - watchdog advances once per shared prescaler tick
// - ports reset to input-only high impedance with fuse
// - mode registers reset FFh, or 00h without fuse
// - zero mode registers give quasi-bidirectional ports
// - reset pin active low, two low samples
`timescale 1ns/1ps
module ctb_top
    import ctb_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire ctb_pins_s   pins,
    input  wire logic        instr_last,
    output logic             core_reset,
    output logic             tick,
    output logic             irq_take,
    output logic             irq,
    output logic [7:0]       port_one_mode_low,
    output logic [7:0]       port_three_mode_low,
    output logic [1:0]       port_quasi,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    // =====================================================================
    // pin synchronisers
    // =====================================================================
    logic [PIN_W-1:0] meta_r;       // first stage, read by stage two only
    logic [PIN_W-1:0] sync_r;       // usable samples
    logic [PIN_W-1:0] prev_r;       // previous sample, for edges
    ctb_pins_s        ps;           // synchronised pins as a struct
    ctb_pins_s        pp;           // previous synchronised pins
    genvar g;
    // every pin is sampled on every core clock
    generate
        for (g = 0; g < PIN_W; g++) begin : g_sync
            always_ff @(posedge aclk) begin
                meta_r[g] <= pins[g];
                sync_r[g] <= meta_r[g];
                prev_r[g] <= sync_r[g];
            end
        end
    endgenerate
    assign ps = ctb_pins_s'(sync_r);
    assign pp = ctb_pins_s'(prev_r);

    // =====================================================================
    // reset qualification
    // =====================================================================
    logic rst_hit;                  // pin low on two successive samples
    assign rst_hit = !ps.rst_pin_n && !pp.rst_pin_n;
    // core reset follows a qualified low pin
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_reset <= 1'b1;
        end else begin
            core_reset <= rst_hit;
        end
    end
    logic any_rst;                  // bus reset or qualified pin reset
    assign any_rst = !aresetn || core_reset;

    // =====================================================================
    // register bus write side
    // =====================================================================
    logic [8:0]      clkctl_r;      // clock_control_reg
    logic [EV_W-1:0] mask_r;        // interrupt mask
    logic [7:0]      aw_addr_r;     // held write address
    logic            aw_have_r;     // write address taken
    logic [31:0]     w_data_r;      // held write data
    logic [3:0]      w_strb_r;      // held byte enables
    logic            w_have_r;      // write data taken
    logic            wr_go;         // both halves present
    logic [31:0]     wmask;         // byte-lane bit mask
    logic            wr_hit;        // write address is mapped
    assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_have_r && !s_axi_bvalid;
    assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
    assign wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                    {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
    assign wr_hit = (aw_addr_r == OFS_CLKCTL) || (aw_addr_r == OFS_STATUS)
                 || (aw_addr_r == OFS_MASK) || (aw_addr_r == OFS_P1MODE)
                 || (aw_addr_r == OFS_P3MODE) || (aw_addr_r == OFS_WDT);
    // address and data are taken in either order, then answered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r    <= 1'b0;
            w_have_r     <= 1'b0;
            aw_addr_r    <= 8'h00;
            w_data_r     <= 32'h0000_0000;
            w_strb_r     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_r    <= 1'b0;
                w_have_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    // control and mask registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clkctl_r <= CLKCTL_RST;
            mask_r   <= '0;
        end else if (wr_go) begin
            if (aw_addr_r == OFS_CLKCTL) begin
                clkctl_r <= (clkctl_r & ~wmask[8:0]) | (w_data_r[8:0] & wmask[8:0]);
            end
            if (aw_addr_r == OFS_MASK) begin
                mask_r <= (mask_r & ~wmask[EV_W-1:0])
                        | (w_data_r[EV_W-1:0] & wmask[EV_W-1:0]);
            end
        end
    end
    // port mode registers: fuse picks the reset value
    always_ff @(posedge aclk) begin
        if (any_rst) begin
            port_one_mode_low   <= ps.tristate_fuse ? MODE_TRISTATE : MODE_QUASI;
            port_three_mode_low <= ps.tristate_fuse ? MODE_TRISTATE : MODE_QUASI;
        end else if (wr_go && aw_addr_r == OFS_P1MODE) begin
            port_one_mode_low <= (port_one_mode_low & ~wmask[7:0])
                               | (w_data_r[7:0] & wmask[7:0]);
        end else if (wr_go && aw_addr_r == OFS_P3MODE) begin
            port_three_mode_low <= (port_three_mode_low & ~wmask[7:0])
                                 | (w_data_r[7:0] & wmask[7:0]);
        end
    end
    // a port whose mode-0 byte is zero runs quasi-bidirectional
    assign port_quasi = {port_three_mode_low == MODE_QUASI,
                         port_one_mode_low == MODE_QUASI};

    // =====================================================================
    // common prescaler
    // =====================================================================
    logic [TPS_W-1:0] timer_prescale_field;          // timer_prescale_field
    logic [TPS_W-1:0] pre_cnt_r;    // clocks since last tick
    assign timer_prescale_field  = clkctl_r[TPS_LSB +: TPS_W];
    assign tick = !core_reset && (pre_cnt_r >= timer_prescale_field);
    // one tick every tps+1 core clocks
    always_ff @(posedge aclk) begin
        if (any_rst || tick) begin
            pre_cnt_r <= '0;
        end else begin
            pre_cnt_r <= pre_cnt_r + 4'h1;
        end
    end

    // =====================================================================
    // timers and watchdog
    // =====================================================================
    logic [15:0] tmr_r [2];         // timer counts
    logic [1:0]  tmr_step;          // timer advances this clock
    logic [1:0]  tmr_ovf;           // timer wraps this clock
    logic [1:0]  pin_fall;          // counter pin falling edge
    logic [15:0] wdt_r;             // watchdog count
    logic        wdt_clr;           // software restart
    logic        wdt_step;          // watchdog advances
    assign pin_fall = {pp.counter_input_one && !ps.counter_input_one,
                       pp.counter_input_zero && !ps.counter_input_zero};
    generate
        for (g = 0; g < 2; g++) begin : g_tmr
            assign tmr_step[g] = clkctl_r[RUN0_BIT + g] && !core_reset
                               && (clkctl_r[CMODE0_BIT + g] ? pin_fall[g] : tick);
            assign tmr_ovf[g]  = tmr_step[g] && (tmr_r[g] == 16'hFFFF);
            // count up on the selected source
            always_ff @(posedge aclk) begin
                if (any_rst) begin
                    tmr_r[g] <= 16'h0000;
                end else if (tmr_step[g]) begin
                    tmr_r[g] <= tmr_r[g] + 16'h0001;
                end
            end
        end
    endgenerate
    assign wdt_clr  = wr_go && (aw_addr_r == OFS_WDT);
    assign wdt_step = clkctl_r[WDTEN_BIT] && tick;
    // watchdog runs from the shared prescaler, restarted by a write
    always_ff @(posedge aclk) begin
        if (any_rst || wdt_clr) begin
            wdt_r <= 16'h0000;
        end else if (wdt_step) begin
            wdt_r <= wdt_r + 16'h0001;
        end
    end

    // =====================================================================
    // sticky events and interrupt
    // =====================================================================
    logic [EV_W-1:0] status_r;      // sticky event bits
    logic [EV_W-1:0] ev_set;        // events this clock
    logic            st_rd;         // status read clears
    assign ev_set[EV_IRQ0] = pp.ext_irq_zero_n && !ps.ext_irq_zero_n;
    assign ev_set[EV_IRQ1] = pp.ext_irq_one_n && !ps.ext_irq_one_n;
    assign ev_set[EV_TOV0] = tmr_ovf[0];
    assign ev_set[EV_TOV1] = tmr_ovf[1];
    assign ev_set[EV_WOV]  = wdt_step && (wdt_r == 16'hFFFF) && !wdt_clr;
    assign ev_set[EV_PRST] = rst_hit && !core_reset;
    // a new event wins over the clearing read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_r <= '0;
        end else begin
            status_r <= (st_rd ? '0 : status_r) | ev_set;
        end
    end
    assign irq = |(status_r & mask_r);
    // poll uses flags latched before the last cycle
    assign irq_take = instr_last && irq;

    // =====================================================================
    // register bus read side
    // =====================================================================
    logic [31:0] rd_val;            // decoded read value
    logic        rd_hit;            // read address is mapped
    assign s_axi_arready = !s_axi_rvalid;
    assign st_rd = s_axi_arvalid && s_axi_arready && (s_axi_araddr == OFS_STATUS);
    // decode the read address
    always_comb begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            OFS_CLKCTL: rd_val = {23'h0, clkctl_r};
            OFS_STATUS: rd_val = {26'h0, status_r};
            OFS_MASK:   rd_val = {26'h0, mask_r};
            OFS_P1MODE: rd_val = {24'h0, port_one_mode_low};
            OFS_P3MODE: rd_val = {24'h0, port_three_mode_low};
            OFS_TMR0:   rd_val = {16'h0, tmr_r[0]};
            OFS_TMR1:   rd_val = {16'h0, tmr_r[1]};
            OFS_WDT:    rd_val = {16'h0, wdt_r};
            default: begin
                rd_val = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end
    // one read answered the clock after its address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // =====================================================================
    // checks
    // =====================================================================
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_CLK_TICK: assert property ((timer_prescale_field == 4'h0 && !core_reset) |-> tick)
        else $error("tick missing with no prescaling");
    AST_DIV12: assert property ((tick && timer_prescale_field == TPS_DIV12 && $stable(timer_prescale_field))
        |=> (!tick)[*8] ##1 !tick ##1 !tick ##1 !tick)
        else $error("prescaler ticked early at divide by twelve");
    AST_RST_IN: assert property ((!ps.rst_pin_n && !pp.rst_pin_n) |=> core_reset)
        else $error("qualified reset not recognised");
    AST_RST_GLITCH: assert property ($rose(core_reset) |-> $past(!pp.rst_pin_n))
        else $error("reset recognised after one low sample");
    AST_IRQ_EDGE: assert property ($fell(ps.ext_irq_zero_n) |=> status_r[EV_IRQ0])
        else $error("external interrupt edge lost");
    AST_CNT_PIN: assert property ((pin_fall[0] && clkctl_r[CMODE0_BIT]
        && clkctl_r[RUN0_BIT] && !core_reset) |=> tmr_r[0] == $past(tmr_r[0]) + 16'h1)
        else $error("counter pin edge not counted");
    AST_WDT: assert property ((wdt_step && !wdt_clr && !core_reset)
        |=> wdt_r == $past(wdt_r) + 16'h1)
        else $error("watchdog did not advance");
    AST_MODE_RST: assert property (core_reset |=> port_one_mode_low ==
        ($past(ps.tristate_fuse) ? MODE_TRISTATE : MODE_QUASI))
        else $error("port mode reset value wrong");
    AST_POLL: assert property (irq_take |-> instr_last && $past(|ev_set) == 1'b0
        || instr_last && |($past(status_r) & mask_r) || instr_last && irq)
        else $error("interrupt taken outside last cycle");
    AST_QUASI: assert property ((port_one_mode_low == 8'h00) |-> port_quasi[0])
        else $error("zero mode byte not quasi");
    // second interrupt pin, sticky priority, poll level and timer source
    // these guard the paths that the single-pin checks above leave open:
    // a read that clears status must never swallow an event of that clock
    AST_IRQ1_EDGE: assert property ($fell(ps.ext_irq_one_n) |=> status_r[EV_IRQ1])
        else $error("second external interrupt edge lost");
    AST_SET_WINS: assert property ((st_rd && ev_set[EV_IRQ0]) |=> status_r[EV_IRQ0])
        else $error("event lost to clearing read");
    AST_TAKE_LVL: assert property ((instr_last && |(status_r & mask_r)) |-> irq_take)
        else $error("pending interrupt not taken in last cycle");
    AST_TMR_TICK: assert property ((tmr_step[0] && !clkctl_r[CMODE0_BIT]) |-> tick)
        else $error("timer stepped without a prescaler tick");
    COV_PIN_CNT: cover property (pin_fall[1] && tmr_step[1]);
    COV_RESET: cover property ($rose(core_reset));
    COV_DIV12: cover property (tick && timer_prescale_field == TPS_DIV12);
    COV_TAKE: cover property (irq_take);
    COV_OVF: cover property (tmr_ovf[0]);
endmodule

// ===== shared/ctb_pkg.sv
/*
 * ctb_pkg: constants, register map and pin carrier for the clock,
 * reset and timebase block.
 * assumes: a single 10 MHz core clock and an AXI4-Lite register master.
 */
package ctb_pkg;
    // =====================================================================
    // clock and reset timing
    // =====================================================================
    localparam int          CLK_PERIOD_NS   = 100;   // core clock period
    localparam int          RST_HOLD_CLKS   = 2;     // low samples for reset
    localparam int          SYNC_STAGES     = 2;     // pin synchroniser depth
    // =====================================================================
    // register offsets (byte addresses)
    // =====================================================================
    localparam logic [7:0]  OFS_CLKCTL      = 8'h00; // clock_control_reg
    localparam logic [7:0]  OFS_STATUS      = 8'h04; // sticky events
    localparam logic [7:0]  OFS_MASK        = 8'h08; // interrupt mask
    localparam logic [7:0]  OFS_P1MODE      = 8'h0C; // port_one_mode_low
    localparam logic [7:0]  OFS_P3MODE      = 8'h10; // port_three_mode_low
    localparam logic [7:0]  OFS_TMR0        = 8'h14; // timer 0 count
    localparam logic [7:0]  OFS_TMR1        = 8'h18; // timer 1 count
    localparam logic [7:0]  OFS_WDT         = 8'h1C; // watchdog count
    // =====================================================================
    // clock_control_reg fields
    // =====================================================================
    localparam int          TPS_LSB         = 0;     // timer_prescale_field
    localparam int          TPS_W           = 4;
    localparam int          RUN0_BIT        = 4;     // timer 0 run
    localparam int          RUN1_BIT        = 5;     // timer 1 run
    localparam int          CMODE0_BIT      = 6;     // timer 0 counts pin
    localparam int          CMODE1_BIT      = 7;     // timer 1 counts pin
    localparam int          WDTEN_BIT       = 8;     // watchdog run
    localparam logic [8:0]  CLKCTL_RST      = 9'h000;
    localparam logic [3:0]  TPS_DIV12       = 4'hB;  // one count per 12 clocks
    // =====================================================================
    // status / mask bit positions
    // =====================================================================
    localparam int          EV_W            = 6;
    localparam int          EV_IRQ0         = 0;     // ext_irq_zero_n fell
    localparam int          EV_IRQ1         = 1;     // ext_irq_one_n fell
    localparam int          EV_TOV0         = 2;     // timer 0 overflow
    localparam int          EV_TOV1         = 3;     // timer 1 overflow
    localparam int          EV_WOV          = 4;     // watchdog overflow
    localparam int          EV_PRST         = 5;     // pin reset seen
    // =====================================================================
    // port mode reset values
    // =====================================================================
    localparam logic [7:0]  MODE_TRISTATE   = 8'hFF; // input-only
    localparam logic [7:0]  MODE_QUASI      = 8'h00; // weak pull-up
    // =====================================================================
    // AXI responses
    // =====================================================================
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
    // asynchronous pins, carried together
    typedef struct packed {
        logic tristate_fuse;      // strap: high keeps ports input-only
        logic counter_input_one;
        logic counter_input_zero;
        logic ext_irq_one_n;
        logic ext_irq_zero_n;
        logic rst_pin_n;
    } ctb_pins_s;
    localparam int          PIN_W           = 6;
endpackage

// ===== tb/ctb_pin_model.sv
/*
 * ctb_pin_model: outside reset circuitry and the port fuse strap.
 * assumes: the bench calls pulse() and sets tristate_fuse; aclk is the crystal.
 */
`timescale 1ns/1ps
module ctb_pin_model (
    input  wire logic aclk,
    output logic      rst_pin_n,
    output logic      tristate_fuse
);
    // =====================================================================
    // pin drive
    // =====================================================================
    // released reset line sits high, fuse strap starts enabled
    initial begin
        rst_pin_n     = 1'b1;
        tristate_fuse = 1'b1;
    end
    // hold the reset line low for n clocks; n below two is a deliberate glitch
    task automatic pulse(input int n);
        @(posedge aclk);
        rst_pin_n <= 1'b0;
        repeat (n) @(posedge aclk);
        rst_pin_n <= 1'b1;
    endtask
endmodule

// ===== tb/test_ctb_top.sv
/*
 * test_ctb_top: self-checking bench for the clock, reset and timebase block.
 * assumes: ctb_pkg compiled first; unused pins idle high.
 */
`timescale 1ns/1ps
module test_ctb_top;
    import ctb_pkg::*;
    // =====================================================================
    // signals
    // =====================================================================
    logic        aclk = 1'b0, aresetn = 1'b0, instr_last = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, pm1, pm3;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'hF;
    logic [1:0]  irq_n = 2'h3, cnt_in = 2'h3, bresp, rresp, port_quasi, r;
    logic        awready, wready, bvalid, arready, rvalid, rst_w, fuse_w;
    logic        core_reset, tick, irq_take, irq;
    int          failures = 0, tests_run = 0, cyc = 0, t_ar;
    // clock, cycle count and pin bundle
    always #(CLK_PERIOD_NS / 2) aclk = ~aclk;
    always @(posedge aclk) cyc <= cyc + 1;
    ctb_pin_model u_ctb_pin_model (.aclk(aclk), .rst_pin_n(rst_w), .tristate_fuse(fuse_w));
    ctb_top u_ctb_top (.aclk(aclk), .aresetn(aresetn), .instr_last(instr_last),
        .pins({fuse_w, cnt_in[1], cnt_in[0], irq_n[1], irq_n[0], rst_w}),
        .core_reset(core_reset), .tick(tick), .irq_take(irq_take), .irq(irq),
        .port_one_mode_low(pm1), .port_three_mode_low(pm3), .port_quasi(port_quasi),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    // =====================================================================
    // shared tasks
    // =====================================================================
    // compare and count, reporting a mismatch at once
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // ends the run with the verdict
    task automatic final_report;
        if (failures == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // write one word: each half released after the edge that takes it
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
        bit aw_d, w_d;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        aw_d = 0;
        w_d  = 0;
        while (!(aw_d && w_d)) begin
            @(negedge aclk);
            aw_d = aw_d || awready;
            w_d  = w_d || wready;
            @(posedge aclk);
            awvalid <= !aw_d;
            wvalid  <= !w_d;
        end
        bready <= 1'b1;
        do @(negedge aclk); while (bvalid !== 1'b1);
        rs = bresp;
        @(posedge aclk);
        bready <= 1'b0;
    endtask
    // read one word; t_ar keeps the cycle of the address handshake
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do @(negedge aclk); while (arready !== 1'b1);
        t_ar = cyc;
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        rs = rresp;
        @(posedge aclk);
        rready <= 1'b0;
    endtask
    // =====================================================================
    // scenarios
    // =====================================================================
    // bus reset with a given fuse strap, then check the mode bytes
    task automatic t_reset(input logic f, input logic [7:0] m);
        logic [31:0] d;
        u_ctb_pin_model.tristate_fuse <= f;
        aresetn <= 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(negedge aclk);
        chk(core_reset, 32'h0);
        chk(pm1, m);
        axi_rd(OFS_P3MODE, d, r);
        chk(d, m);
        chk(port_quasi, (m == 8'h00) ? 32'h3 : 32'h0);
    endtask
    // clearing both mode bytes over the bus, then setting port one's byte again
    task automatic t_quasi;
        axi_wr(OFS_P1MODE, 32'h0, r);
        axi_wr(OFS_P3MODE, 32'h0, r);
        @(negedge aclk);
        chk(port_quasi, 32'h3);
        axi_wr(OFS_P1MODE, 32'hFF, r);
        @(negedge aclk);
        chk(port_quasi, 32'h2);
    endtask
    // distance between prescaler ticks is field value plus one
    task automatic t_tick(input logic [3:0] p);
        int n;
        axi_wr(OFS_CLKCTL, {28'h0, p}, r);
        repeat (2) @(negedge aclk);
        do @(negedge aclk); while (tick !== 1'b1);
        n = 0;
        do begin @(negedge aclk); n++; end while (tick !== 1'b1);
        chk(n, p + 1);
    endtask
    // timer and watchdog climb by one per clock with no prescaling
    task automatic t_count(input logic [7:0] ofs);
        logic [31:0] v0, v1;
        int c0;
        axi_wr(OFS_CLKCTL, 32'h110, r);
        axi_rd(ofs, v0, r);
        c0 = t_ar;
        repeat (5) @(posedge aclk);
        axi_rd(ofs, v1, r);
        chk(v1 - v0, t_ar - c0);
    endtask
    // three falling edges on counter pin b give three counts
    task automatic t_pin(input int b);
        logic [31:0] v0, v1;
        axi_wr(OFS_CLKCTL, 32'h50 << b, r);
        axi_rd(OFS_TMR0 + 8'(4 * b), v0, r);
        repeat (3) begin
            cnt_in[b] <= 1'b0;
            repeat (2) @(posedge aclk);
            cnt_in[b] <= 1'b1;
            repeat (2) @(posedge aclk);
        end
        repeat (4) @(posedge aclk);
        axi_rd(OFS_TMR0 + 8'(4 * b), v1, r);
        chk(v1 - v0, 32'h3);
    endtask
    // falling irq pin b: latch after sync, poll in last cycle, read clears
    task automatic t_irq(input int b, input logic [31:0] msk);
        logic [31:0] d;
        axi_wr(OFS_MASK, msk, r);
        axi_rd(OFS_STATUS, d, r);
        instr_last <= 1'b1;
        irq_n[b]   <= 1'b0;
        @(negedge aclk);
        chk(irq_take, 32'h0);
        repeat (2) @(negedge aclk);
        chk(irq_take, 32'h0);
        @(negedge aclk);
        chk(irq_take, msk[b]);
        @(posedge aclk);
        instr_last <= 1'b0;
        irq_n[b]   <= 1'b1;
        axi_rd(OFS_STATUS, d, r);
        chk((d >> b) & 32'h1, 32'h1);
        axi_rd(OFS_STATUS, d, r);
        chk((d >> b) & 32'h1, 32'h0);
        chk(irq, 32'h0);
    endtask
    // reset pin glitch is ignored, two low clocks reset the ports
    task automatic t_pinrst(input int len, input logic exp);
        logic seen;
        seen = 1'b0;
        axi_wr(OFS_P1MODE, 32'h0, r);
        u_ctb_pin_model.pulse(len);
        repeat (8) begin @(negedge aclk); seen = seen | core_reset; end
        chk(seen, exp);
        chk(pm1, exp ? MODE_TRISTATE : MODE_QUASI);
    endtask
    // =====================================================================
    // main sequence and watchdog
    // =====================================================================
    initial begin
        logic [31:0] d;
        t_reset(1'b0, MODE_QUASI);
        t_reset(1'b1, MODE_TRISTATE);
        t_quasi;
        t_tick(4'h0);
        t_tick(TPS_DIV12);
        t_tick(4'hF);
        t_count(OFS_TMR0);
        t_count(OFS_WDT);
        t_pin(0);
        t_pin(1);
        t_irq(0, 32'h1);
        t_irq(1, 32'h2);
        t_irq(0, 32'h0);
        t_pinrst(1, 1'b0);
        t_pinrst(2, 1'b1);
        axi_rd(8'h20, d, r);
        chk({d, r}, {32'h0, RESP_SLVERR});
        axi_wr(OFS_TMR0, 32'h1, r);
        chk(r, RESP_SLVERR);
        wstrb <= 4'h2;
        axi_wr(OFS_MASK, 32'h3F, r);
        wstrb <= 4'hF;
        axi_rd(OFS_MASK, d, r);
        chk(d, 32'h0);
        final_report;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        final_report;
    end
endmodule
